/* hcirq_ctl_slave.sv */
// Serial control bus slave with a 7-bit address and 8-bit register pointer.
// Assumes scl and sda are already synchronised to clk.
module hcirq_ctl_slave
  import hcirq_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       scl_s,
  input  wire logic       sda_s,
  input  wire logic       gate_high,
  input  wire logic [6:0] slave_addr,
  input  wire logic [7:0] rd_data,
  output logic            sda_oe_n,
  output logic [7:0]      reg_addr,
  output logic [7:0]      wr_data,
  output logic            wr_stb,
  output logic            rd_stb
);

  hcirq_state_t state_reg;
  logic         scl_d_reg;
  logic         sda_d_reg;
  logic [3:0]   bit_cnt_reg;
  logic [7:0]   shift_reg;
  logic         rnw_reg;
  logic         have_ptr_reg;
  logic         drive_low_reg;
  wire          scl_rise = scl_s & ~scl_d_reg;
  wire          scl_fall = ~scl_s & scl_d_reg;
  wire          start_c  = scl_s & sda_d_reg & ~sda_s;
  wire          stop_c   = scl_s & ~sda_d_reg & sda_s;

  always_ff @(posedge clk) begin
    if (rst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign sda_oe_n = ~drive_low_reg;

  always_ff @(posedge clk) begin
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    if (rst || gate_high || stop_c) begin
      state_reg     <= HCIRQ_IDLE;
      drive_low_reg <= 1'b0;
      bit_cnt_reg   <= 4'h0;
      shift_reg     <= 8'h00;
      rnw_reg       <= 1'b0;
      have_ptr_reg  <= 1'b0;
      reg_addr      <= 8'h00;
      wr_data       <= 8'h00;
    end else if (start_c) begin
      state_reg     <= HCIRQ_ADDR;
      bit_cnt_reg   <= 4'h0;
      drive_low_reg <= 1'b0;
      have_ptr_reg  <= 1'b0;
    end else begin
      unique case (state_reg)
        HCIRQ_IDLE: ;
        HCIRQ_ADDR: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          if (scl_fall && bit_cnt_reg == 4'h8) begin
            if (shift_reg[7:1] == slave_addr) begin
              rnw_reg       <= shift_reg[0];
              drive_low_reg <= 1'b1;
              state_reg     <= HCIRQ_AACK;
            end else begin
              state_reg <= HCIRQ_IDLE;
            end
          end
        end
        HCIRQ_AACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (rnw_reg) begin
              rd_stb        <= 1'b1;
              shift_reg     <= rd_data;
              drive_low_reg <= ~rd_data[7];
              state_reg     <= HCIRQ_RTX;
            end else begin
              drive_low_reg <= 1'b0;
              state_reg     <= HCIRQ_WRX;
            end
          end
        end
        HCIRQ_WRX: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          if (scl_fall && bit_cnt_reg == 4'h8) begin
            if (have_ptr_reg) begin
              wr_data  <= shift_reg;
              wr_stb   <= 1'b1;
            end else begin
              reg_addr <= shift_reg;
            end
            drive_low_reg <= 1'b1;
            state_reg     <= HCIRQ_WACK;
          end
        end
        HCIRQ_WACK: begin
          if (scl_fall) begin
            if (have_ptr_reg) begin
              reg_addr <= reg_addr + 8'h01;
            end
            have_ptr_reg  <= 1'b1;
            drive_low_reg <= 1'b0;
            bit_cnt_reg   <= 4'h0;
            state_reg     <= HCIRQ_WRX;
          end
        end
        HCIRQ_RTX: begin
          if (scl_fall) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'h7) begin
              drive_low_reg <= 1'b0;
              state_reg     <= HCIRQ_RACK;
            end else begin
              drive_low_reg <= ~shift_reg[6];
              shift_reg     <= {shift_reg[6:0], 1'b0};
            end
          end
        end
        HCIRQ_RACK: begin
          if (scl_rise) begin
            rnw_reg <= ~sda_s;
          end
          if (scl_fall) begin
            if (rnw_reg) begin
              reg_addr      <= reg_addr + 8'h01;
              rd_stb        <= 1'b1;
              shift_reg     <= rd_data;
              drive_low_reg <= ~rd_data[7];
              bit_cnt_reg   <= 4'h0;
              state_reg     <= HCIRQ_RTX;
            end else begin
              state_reg <= HCIRQ_IDLE;
            end
          end
        end
        default: state_reg <= HCIRQ_IDLE;
      endcase
    end
  end

  property p_gate_silent;
    @(posedge clk) disable iff (rst) gate_high |=> sda_oe_n && !wr_stb;
  endproperty
  a_gate_silent: assert property (p_gate_silent) else $error("bus acted while gated");

endmodule

/* hcirq_host_model.sv */
// Host controller model: serial control bus master with an open-drain data line.
// Assumes a pull-up on the data line; the testbench resolves the wire level.
module hcirq_host_model (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda_line
);
  timeunit 1ns;
  timeprecision 100ps;

  // Link clock stands high between frames, 80 ns per bit
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      #20 scl = 1'b1;
      #40 scl = 1'b0;
      #20;
    end
    // Release data so the device can acknowledge
    sda_low = 1'b0;
    #20 scl = 1'b1;
    #20 ack = ~sda_line;
    #20 scl = 1'b0;
    #20;
  endtask

  task automatic write_reg(input logic [7:0] dev, input logic [7:0] ptr,
                           input logic [7:0] dat, output logic ok);
    logic a0;
    logic a1;
    logic a2;
    a1 = 1'b0;
    a2 = 1'b0;
    #7 sda_low = 1'b1;
    #20 scl = 1'b0;
    #20 send_byte(dev, a0);
    if (a0) begin
      send_byte(ptr, a1);
      send_byte(dat, a2);
    end
    sda_low = 1'b1;
    #20 scl = 1'b1;
    #20 sda_low = 1'b0;
    #40 ok = a0 & a1 & a2;
  endtask

  // Read one byte from the current pointer, then not-acknowledge and stop
  task automatic read_reg(input logic [7:0] dev, output logic [7:0] dat, output logic ok);
    logic a0;
    dat = 8'h00;
    #7 sda_low = 1'b1;
    #20 scl = 1'b0;
    #20 send_byte(dev, a0);
    for (int i = 7; i >= 0; i--) begin
      #20 scl = 1'b1;
      #20 dat[i] = sda_line;
      #20 scl = 1'b0;
      #20;
    end
    #20 scl = 1'b1;
    #40 scl = 1'b0;
    #20 sda_low = 1'b1;
    #20 scl = 1'b1;
    #20 sda_low = 1'b0;
    #40 ok = a0;
  endtask
endmodule

/* hcirq_pkg.sv */
// Package for the host control, interrupt and reset port block.
// Assumes a 200 MHz system clock and one serial control bus master outside.
package hcirq_pkg;

  localparam int unsigned CLK_MHZ         = 200;
  localparam int unsigned RST_MIN_MS      = 5;
  localparam int unsigned RST_MIN_CYCLES  = RST_MIN_MS * CLK_MHZ * 1000;
  localparam int unsigned REF_OSC_HZ      = 28636360;

  localparam logic [6:0] SLAVE_ADDR_DFLT  = 7'h4C;
  localparam logic [6:0] SLAVE_ADDR_ALT   = 7'h4D;

  localparam logic [7:0] REG_STATUS       = 8'h00;
  localparam logic [7:0] REG_MASK         = 8'h01;
  localparam logic [7:0] REG_CTRL         = 8'h02;
  localparam logic [7:0] REG_RAW          = 8'h03;
  localparam logic [7:0] REG_CMD          = 8'h04;

  localparam int unsigned CTRL_POL_BIT    = 0;
  localparam int unsigned CTRL_SEL_LSB    = 1;
  localparam int unsigned CMD_LATCH_BIT   = 0;

  localparam logic [7:0] MASK_RST         = 8'h00;
  localparam logic [7:0] CTRL_RST         = 8'h00;

  localparam logic [1:0] SEL_NONE         = 2'b00;
  localparam logic [1:0] SEL_BITCLK       = 2'b01;
  localparam logic [1:0] SEL_MASTERCLK    = 2'b10;
  localparam logic [1:0] SEL_ATTACH       = 2'b11;

  typedef enum logic [2:0] {
    HCIRQ_IDLE  = 3'b000,
    HCIRQ_ADDR  = 3'b001,
    HCIRQ_AACK  = 3'b010,
    HCIRQ_WRX   = 3'b011,
    HCIRQ_WACK  = 3'b100,
    HCIRQ_RTX   = 3'b101,
    HCIRQ_RACK  = 3'b110
  } hcirq_state_t;

endpackage

/* hcirq_top.sv */
// Host control, interrupt and reset port block of a video receiver.
// Assumes rst_n, scl, sda_in, gate and strap pins are asynchronous to clk.
// Function
// - Primary interrupt polarity is selectable in configuration.
// - Interrupt fires on status bit change; events selectable by mask.
// - Secondary interrupt routable to bit-clock, master-clock or attach pin.
// - Attach pin drives attach level or secondary interrupt, never both.
// - Gate input high makes control slave ignore all transactions.
// - Reset input is active low and holds all logic in reset; the input synchronisers are cleared only by rst.
// - Reference clock is a 28.63636 MHz crystal or oscillator.
// - Address strap shares the vertical sync and field pin.
// - Slave address 0x98 after reset; 0x9A after strap high plus latch command.
// - Slave takes bus clock as input, drives data for reads and acks.
//
// The placing of the registers and strobed register access were left to the implementer.
module hcirq_top
  import hcirq_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ref_osc_input,
  input  wire logic       rst_n_pin,
  input  wire logic       gate_pin,
  input  wire logic       scl_pin,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  input  wire logic       vsync_field_addr_pin,
  input  wire logic [7:0] status_in,
  input  wire logic       audio_bitclk,
  input  wire logic       audio_masterclk,
  input  wire logic       port_a_attach,
  input  wire logic [7:0] bus_addr,
  input  wire logic [7:0] bus_wdata,
  input  wire logic       bus_wr,
  input  wire logic       bus_rd,
  output logic [7:0]      bus_rdata,
  output logic            primary_irq_out,
  output logic            secondary_irq_out,
  output logic            audio_bitclk_or_irq_pin,
  output logic            audio_masterclk_or_irq_pin,
  output logic            port_a_attach_or_irq_pin,
  output logic            ref_crystal_return,
  output logic            int_rst
);

  logic [1:0] rstn_sync_reg;
  logic [1:0] gate_sync_reg;
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic [1:0] strap_sync_reg;
  logic [7:0] stat_sync1_reg;
  logic [7:0] stat_sync2_reg;
  logic [7:0] stat_prev_reg;
  logic [7:0] pend_reg;
  logic [7:0] mask_reg;
  logic [7:0] ctrl_reg;
  logic       alt_addr_reg;
  logic [6:0] slave_addr;
  logic [7:0] ra;
  logic [7:0] wd;
  logic       ws;
  logic       rs;
  logic [7:0] rd_mux;
  logic       any_irq;
  logic [1:0] sel;
  logic       srst;

  // Inverter for the crystal loop
  assign ref_crystal_return = ~ref_osc_input;

  always_ff @(posedge clk) begin
    if (rst) begin
      rstn_sync_reg  <= 2'b00;
      gate_sync_reg  <= 2'b11;
      scl_sync_reg   <= 2'b11;
      sda_sync_reg   <= 2'b11;
      strap_sync_reg <= 2'b00;
      stat_sync1_reg <= 8'h00;
      stat_sync2_reg <= 8'h00;
    end else begin
      rstn_sync_reg  <= {rstn_sync_reg[0], rst_n_pin};
      gate_sync_reg  <= {gate_sync_reg[0], gate_pin};
      scl_sync_reg   <= {scl_sync_reg[0], scl_pin};
      sda_sync_reg   <= {sda_sync_reg[0], sda_in};
      strap_sync_reg <= {strap_sync_reg[0], vsync_field_addr_pin};
      stat_sync1_reg <= status_in;
      stat_sync2_reg <= stat_sync1_reg;
    end
  end

  // All but the input synchronisers held while the pin is low
  assign srst    = rst | ~rstn_sync_reg[1];
  assign int_rst = srst;

  assign sda_out    = 1'b0;
  assign slave_addr = alt_addr_reg ? SLAVE_ADDR_ALT : SLAVE_ADDR_DFLT;

  hcirq_ctl_slave u_slave (
    .clk        (clk),
    .rst        (srst),
    .scl_s      (scl_sync_reg[1]),
    .sda_s      (sda_sync_reg[1]),
    .gate_high  (gate_sync_reg[1]),
    .slave_addr (slave_addr),
    .rd_data    (rd_mux),
    .sda_oe_n   (sda_oe_n),
    .reg_addr   (ra),
    .wr_data    (wd),
    .wr_stb     (ws),
    .rd_stb     (rs)
  );

  function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] p,
                                          input logic [7:0] m, input logic [7:0] c,
                                          input logic [7:0] r);
    unique case (a)
      REG_STATUS: reg_read = p;
      REG_MASK:   reg_read = m;
      REG_CTRL:   reg_read = c;
      REG_RAW:    reg_read = r;
      default:    reg_read = 8'h00;
    endcase
  endfunction

  assign rd_mux = reg_read(ra, pend_reg, mask_reg, ctrl_reg, stat_sync2_reg);

  always_ff @(posedge clk) begin
    if (srst) begin
      mask_reg <= MASK_RST;
      ctrl_reg <= CTRL_RST;
    end else if (ws) begin
      if (ra == REG_MASK) begin
        mask_reg <= wd;
      end
      if (ra == REG_CTRL) begin
        ctrl_reg <= wd;
      end
    end else if (bus_wr) begin
      if (bus_addr == REG_MASK) begin
        mask_reg <= bus_wdata;
      end
      if (bus_addr == REG_CTRL) begin
        ctrl_reg <= bus_wdata;
      end
    end
  end

  // Strap is sampled only on command, never at reset
  always_ff @(posedge clk) begin
    if (srst) begin
      alt_addr_reg <= 1'b0;
    end else if ((ws && ra == REG_CMD && wd[CMD_LATCH_BIT]) ||
                 (bus_wr && bus_addr == REG_CMD && bus_wdata[CMD_LATCH_BIT])) begin
      alt_addr_reg <= strap_sync_reg[1];
    end
  end

  // Change events are sticky; a new event wins over the read clear
  always_ff @(posedge clk) begin
    if (srst) begin
      stat_prev_reg <= 8'h00;
      pend_reg      <= 8'h00;
    end else begin
      stat_prev_reg <= stat_sync2_reg;
      if ((rs && ra == REG_STATUS) || (bus_rd && bus_addr == REG_STATUS)) begin
        pend_reg <= stat_sync2_reg ^ stat_prev_reg;
      end else begin
        pend_reg <= pend_reg | (stat_sync2_reg ^ stat_prev_reg);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bus_rdata <= 8'h00;
    end else if (bus_rd) begin
      bus_rdata <= reg_read(bus_addr, pend_reg, mask_reg, ctrl_reg, stat_sync2_reg);
    end else begin
      bus_rdata <= 8'h00;
    end
  end

  assign any_irq = |(pend_reg & mask_reg);
  assign sel     = ctrl_reg[CTRL_SEL_LSB +: 2];

  always_ff @(posedge clk) begin
    if (srst) begin
      primary_irq_out   <= 1'b0;
      secondary_irq_out <= 1'b0;
    end else begin
      primary_irq_out   <= any_irq ^ ctrl_reg[CTRL_POL_BIT];
      secondary_irq_out <= any_irq;
    end
  end

  // Shared pins keep their normal function unless selected
  always_comb begin
    audio_bitclk_or_irq_pin    = (sel == SEL_BITCLK) ? secondary_irq_out : audio_bitclk;
    audio_masterclk_or_irq_pin = (sel == SEL_MASTERCLK) ? secondary_irq_out
                                                        : audio_masterclk;
    port_a_attach_or_irq_pin   = (sel == SEL_ATTACH) ? secondary_irq_out : port_a_attach;
  end

  property p_irq_follows;
    @(posedge clk) disable iff (srst)
      (any_irq && !ctrl_reg[CTRL_POL_BIT]) |=> primary_irq_out;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("primary irq missing");

  property p_irq_polarity;
    @(posedge clk) disable iff (srst)
      (!any_irq && $stable(ctrl_reg)) |=> primary_irq_out == $past(ctrl_reg[CTRL_POL_BIT]);
  endproperty
  a_irq_polarity: assert property (p_irq_polarity) else $error("idle level wrong");

  property p_change_sets;
    @(posedge clk) disable iff (srst)
      (stat_sync2_reg != stat_prev_reg) |=> pend_reg != 8'h00;
  endproperty
  a_change_sets: assert property (p_change_sets) else $error("change not latched");

  property p_sticky;
    @(posedge clk) disable iff (srst)
      (pend_reg != 8'h00 && !rs && !bus_rd) |=> pend_reg != 8'h00;
  endproperty
  a_sticky: assert property (p_sticky) else $error("pending flag lost");

  property p_attach_route;
    @(posedge clk) disable iff (srst)
      sel == SEL_ATTACH |-> port_a_attach_or_irq_pin == secondary_irq_out;
  endproperty
  a_attach_route: assert property (p_attach_route) else $error("attach routing wrong");

  property p_bitclk_route;
    @(posedge clk) disable iff (srst)
      sel != SEL_BITCLK |-> audio_bitclk_or_irq_pin == audio_bitclk;
  endproperty
  a_bitclk_route: assert property (p_bitclk_route) else $error("bit clock disturbed");

  property p_addr_dflt;
    @(posedge clk) $fell(srst) |-> slave_addr == SLAVE_ADDR_DFLT;
  endproperty
  a_addr_dflt: assert property (p_addr_dflt) else $error("address not default");

  property p_rst_hold;
    @(posedge clk) disable iff (rst) !rstn_sync_reg[1] |=> !primary_irq_out || ctrl_reg[0];
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset not holding");

endmodule

/* hcirq_top_tb.sv */
// Self-checking testbench of the host control, interrupt and reset port block.
// Assumes the host model drives the serial bus and the bench the register port.
module hcirq_top_tb
  import hcirq_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk;
  logic       rst;
  logic       rst_n_pin;
  logic       gate_pin;
  logic       strap;
  logic [7:0] status_in;
  logic       bitclk;
  logic       mclk;
  logic       attach;
  logic [7:0] bus_addr;
  logic [7:0] bus_wdata;
  logic       bus_wr;
  logic       bus_rd;
  logic [7:0] bus_rdata;
  logic       sda_out;
  logic       sda_oe_n;
  logic       scl;
  logic       sda_low;
  logic       sda_line;
  logic       p_irq;
  logic       s_irq;
  logic       pin_bc;
  logic       pin_mc;
  logic       pin_at;
  logic       int_rst;
  logic       ok;
  logic       xtal_ret;
  logic [7:0] rdat;
  int         n_errors;
  int         samples_checked;

  assign sda_line = ~(sda_low | ~sda_oe_n);

  hcirq_host_model i_hcirq_host_model (.scl(scl), .sda_low(sda_low), .sda_line(sda_line));

  hcirq_top i_hcirq_top (
    .clk(clk), .rst(rst), .ref_osc_input(clk), .rst_n_pin(rst_n_pin),
    .gate_pin(gate_pin), .scl_pin(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .vsync_field_addr_pin(strap), .status_in(status_in),
    .audio_bitclk(bitclk), .audio_masterclk(mclk), .port_a_attach(attach),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .primary_irq_out(p_irq), .secondary_irq_out(s_irq),
    .audio_bitclk_or_irq_pin(pin_bc), .audio_masterclk_or_irq_pin(pin_mc),
    .port_a_attach_or_irq_pin(pin_at), .ref_crystal_return(xtal_ret), .int_rst(int_rst));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge clk);
    bus_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge clk);
    bus_rd   <= 1'b0;
    #1 chk(bus_rdata, exp);
  endtask

  task automatic wait_irq(input logic lvl);
    for (int i = 0; i < 20 && p_irq !== lvl; i++) @(posedge clk);
    chk({7'h0, p_irq}, {7'h0, lvl});
  endtask

  task automatic t_reset_vals();
    rd(REG_MASK, MASK_RST);
    rd(REG_CTRL, CTRL_RST);
    rd(8'h10, 8'h00);
    chk({6'h0, p_irq, s_irq}, 8'h00);
    chk({6'h0, sda_out, xtal_ret}, 8'h00);
  endtask

  task automatic t_irq();
    wr(REG_MASK, 8'h01);
    @(posedge clk) status_in[1] <= 1'b1;
    repeat (10) @(posedge clk);
    chk({7'h0, p_irq}, 8'h00);
    rd(REG_STATUS, 8'h02);
    @(posedge clk) status_in[0] <= 1'b1;
    wait_irq(1'b1);
    rd(REG_STATUS, 8'h01);
    wait_irq(1'b0);
    rd(REG_RAW, 8'h03);
    wr(REG_CTRL, 8'h01);
    repeat (3) @(posedge clk);
    chk({7'h0, p_irq}, 8'h01);
    wr(REG_CTRL, 8'h00);
  endtask

  task automatic t_route();
    logic [1:0] s;
    @(posedge clk) status_in[0] <= 1'b0;
    wait_irq(1'b1);
    for (int k = 0; k < 4; k++) begin
      s = k[1:0];
      wr(REG_CTRL, {5'h0, s, 1'b0});
      repeat (3) @(posedge clk);
      chk({5'h0, pin_bc, pin_mc, pin_at}, {5'h0, s == SEL_BITCLK, s == SEL_MASTERCLK,
          s == SEL_ATTACH});
      @(posedge clk) attach <= 1'b1;
      repeat (2) @(posedge clk);
      chk({7'h0, pin_at}, {7'h0, 1'b1});
      @(posedge clk) attach <= 1'b0;
    end
    rd(REG_STATUS, 8'h01);
    wait_irq(1'b0);
    chk({7'h0, s_irq}, 8'h00);
  endtask

  task automatic t_serial();
    @(posedge clk) gate_pin <= 1'b1;
    i_hcirq_host_model.write_reg(8'h98, REG_MASK, 8'hAA, ok);
    chk({7'h0, ok}, 8'h00);
    rd(REG_MASK, 8'h01);
    @(posedge clk) gate_pin <= 1'b0;
    i_hcirq_host_model.write_reg(8'h98, REG_MASK, 8'h55, ok);
    chk({7'h0, ok}, 8'h01);
    rd(REG_MASK, 8'h55);
    i_hcirq_host_model.write_reg(8'h9A, REG_MASK, 8'h11, ok);
    chk({7'h0, ok}, 8'h00);
    @(posedge clk) strap <= 1'b1;
    i_hcirq_host_model.write_reg(8'h98, REG_CMD, 8'h01, ok);
    i_hcirq_host_model.write_reg(8'h9A, REG_MASK, 8'h33, ok);
    chk({7'h0, ok}, 8'h01);
    rd(REG_MASK, 8'h33);
    @(posedge clk) status_in[2] <= 1'b1;
    repeat (5) @(posedge clk);
    i_hcirq_host_model.read_reg(8'h9B, rdat, ok);
    chk({7'h0, ok}, 8'h01);
    chk(rdat, 8'h04);
    rd(REG_STATUS, 8'h00);
  endtask

  task automatic t_pin_reset();
    @(posedge clk) rst_n_pin <= 1'b0;
    repeat (5) @(posedge clk);
    chk({7'h0, int_rst}, 8'h01);
    @(posedge clk) rst_n_pin <= 1'b1;
    repeat (5) @(posedge clk);
    rd(REG_MASK, MASK_RST);
    i_hcirq_host_model.write_reg(8'h98, REG_MASK, 8'h00, ok);
    chk({7'h0, ok}, 8'h01);
  endtask

  task automatic end_sim();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #200_000;
    n_errors++;
    end_sim();
  end

  initial begin
    n_errors        = 0;
    samples_checked = 0;
    rst       = 1'b1;
    // Reset pin low while supplies come up; pulse shortened, width not checked
    rst_n_pin = 1'b0;
    gate_pin  = 1'b0;
    strap     = 1'b0;
    status_in = 8'h00;
    bitclk    = 1'b0;
    mclk      = 1'b0;
    attach    = 1'b0;
    bus_addr  = 8'h00;
    bus_wdata = 8'h00;
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
    repeat (5) @(posedge clk);
    rst       <= 1'b0;
    rst_n_pin <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset_vals();
    t_irq();
    t_route();
    t_serial();
    t_pin_reset();
    end_sim();
  end
endmodule
